// >>> flash_far_model.sv
// Far-side model: RAM holding the row image, and the flash array's program and erase ports
`timescale 1ns/1ns
`default_nettype none
module flash_far_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_clear,
  input wire logic i_ram_rd,
  input wire logic [15:0] i_ram_addr,
  output logic [15:0] o_ram_data,
  input wire logic i_erase,
  input wire logic i_write,
  input wire logic [23:0] i_addr,
  input wire logic [23:0] i_data,
  output logic [15:0] o_reads,
  output logic [15:0] o_last_raddr,
  output logic [15:0] o_writes,
  output logic [15:0] o_erases,
  output logic [23:0] o_erase_addr,
  output logic [23:0] o_first_addr,
  output logic [23:0] o_first_data,
  output logic [23:0] o_last_addr,
  output logic [23:0] o_last_data,
  output logic [23:0] o_first_data2,
  output logic [23:0] o_last_data2
);
  // ==========================================================
  // RAM read port
  // Reply stands while the strobe does; outside it the bus keeps changing, so a misplaced sample is caught
  logic [15:0] noise;
  logic write_d;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst)
      noise <= 16'h0000;
    else
      noise <= ~noise + 16'h1357;
  end
  assign o_ram_data = i_ram_rd ? {i_ram_addr[7:0] ^ 8'h3C, i_ram_addr[8:1]} : noise;
  // ==========================================================
  // Flash array activity log
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst || i_clear) begin
      o_reads <= 16'h0000;
      o_last_raddr <= 16'h0000;
      o_writes <= 16'h0000;
      o_erases <= 16'h0000;
      o_erase_addr <= 24'h000000;
      o_first_addr <= 24'h000000;
      o_first_data <= 24'h000000;
      o_last_addr <= 24'h000000;
      o_last_data <= 24'h000000;
      write_d <= 1'b0;
      o_first_data2 <= 24'h000000;
      o_last_data2 <= 24'h000000;
    end else begin
      if (i_ram_rd) begin
        o_reads <= o_reads + 16'h0001;
        o_last_raddr <= i_ram_addr;
      end
      if (i_write) begin
        if (o_writes == 16'h0000) begin
          o_first_addr <= i_addr;
          o_first_data <= i_data;
        end
        o_writes <= o_writes + 16'h0001;
        o_last_addr <= i_addr;
        o_last_data <= i_data;
      end
      if (i_erase) begin
        o_erases <= o_erases + 16'h0001;
        o_erase_addr <= i_addr;
      end
      // Second instruction of a pair stands in the cycle after the write pulse
      write_d <= i_write;
      if (write_d) begin
        if (o_writes == 16'h0001)
          o_first_data2 <= i_data;
        o_last_data2 <= i_data;
      end
    end
  end
endmodule : flash_far_model
`default_nettype wire

// >>> flash_row_unpack.sv
// RAM row image word to instruction pair unpacker
`timescale 1ns/1ns
`default_nettype none
module flash_row_unpack
  import flash_seq_pkg::*;
(
  input wire logic i_compressed,
  input wire logic [15:0] i_w0,
  input wire logic [15:0] i_w1,
  input wire logic [15:0] i_w2,
  input wire logic [15:0] i_w3,
  output logic [23:0] o_instr0,
  output logic [23:0] o_instr1
);
  // Uncompressed: lsw,msb-word per instruction; compressed: three words per pair
  always_comb begin
    if (i_compressed) begin
      o_instr0 = {i_w1[7:0], i_w0};
      o_instr1 = {i_w1[15:8], i_w2};
    end else begin
      o_instr0 = {i_w1[7:0], i_w0};
      o_instr1 = {i_w3[7:0], i_w2};
    end
  end
endmodule : flash_row_unpack
`default_nettype wire

// >>> flash_self_program_sequencer.sv
// Flash self-programming sequencer: registers, unlock, erase/row/pair sequencing
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Array rows hold 64 instructions, 192 bytes; row is the row-program unit.
// - Erase clears one eight-row page; program writes one row or one pair.
// - Pages align to 1536 bytes, rows to 192 bytes from memory start.
// - Row write fetches RAM into latches itself, advancing both pointers; here RAM words go to wbuf, latch0/latch1 untouched.
// - Control bit 9 selects compressed or uncompressed row image.
// - Compressed: second word upper byte is second instruction top byte.
// - Successful erase or program can raise an enabled completion interrupt.
// - Processor is stalled while an erase or program runs.
// - Control bit 15 starts; hardware clears it when finished.
// - Pair programming only at addresses stepping by four.
// - No operation runs without the unlock key sequence first.
module flash_self_program_sequencer
  import flash_seq_pkg::*;
#(
  parameter int ERASE_WAIT = ERASE_CYCLES,
  parameter int WORD_WAIT = WORD_CYCLES,
  parameter int KEY_WINDOW = KEY_WINDOW_CYCLES,
  parameter logic [15:0] KEY_A = KEY_FIRST,
  parameter logic [15:0] KEY_B = KEY_SECOND
) (
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  input wire logic [3:0] I_ADDR,
  input wire logic [23:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [23:0] O_RDATA,
  output logic O_IRQ,
  output logic O_CPU_STALL,
  output logic O_RAM_RD,
  output logic [15:0] O_RAM_ADDR,
  input wire logic [15:0] I_RAM_DATA,
  output logic O_FLASH_ERASE,
  output logic O_FLASH_WRITE,
  output logic [23:0] O_FLASH_ADDR,
  output logic [23:0] O_FLASH_DATA
);
  // ==========================================================
  // Elaboration checks
  initial begin
    if (ERASE_WAIT < 1 || WORD_WAIT < 1 || KEY_WINDOW < 1 || ERASE_WAIT > 65535 || WORD_WAIT > 65535)
      $error("flash sequencer: timing parameter out of range");
  end

  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,
    S_ERASE = 6'b000010,
    S_FETCH = 6'b000100,
    S_WAITD = 6'b001000,
    S_PROG  = 6'b010000,
    S_DONE  = 6'b100000
  } seq_state_e;

  seq_state_e state;
  logic start;
  logic format;
  logic [1:0] op;
  logic [15:0] src;
  logic [23:0] tgt;
  logic [23:0] latch0;
  logic [23:0] latch1;
  logic [1:0] key_stage;
  logic [7:0] key_age;
  logic [15:0] wait_cnt;
  logic [2:0] word_idx;
  logic [15:0] wbuf [0:3];
  logic [6:0] pair_cnt;
  logic [2:0] irq_status;
  logic [2:0] irq_enable;
  logic [2:0] irq_set;
  logic [23:0] up0;
  logic [23:0] up1;
  logic unlocked;
  logic wr_ctl;
  logic go;
  logic aligned;
  logic [2:0] words_per_pair;

  function automatic logic [23:0] mod_addr(input logic [23:0] a, input int unit);
    mod_addr = a % 24'(unit);
  endfunction : mod_addr

  // Program addresses step two per instruction; byte offset is 3/2 of address
  assign unlocked = (key_stage == 2'h2);
  assign wr_ctl = I_WR && (I_ADDR == OFS_CONTROL);
  assign go = wr_ctl && I_WDATA[CTL_START_BIT] && (state == S_IDLE);
  assign words_per_pair = format ? 3'h3 : 3'h4;

  always_comb begin
    aligned = 1'b0;
    if (I_WDATA[CTL_OP_LSB +: 2] == OP_ERASE)
      aligned = (mod_addr(tgt, PAGE_INSTR * 2) == 24'h0);
    else if (I_WDATA[CTL_OP_LSB +: 2] == OP_ROW)
      aligned = (mod_addr(tgt, ROW_INSTR * 2) == 24'h0);
    else if (I_WDATA[CTL_OP_LSB +: 2] == OP_PAIR)
      aligned = (mod_addr(tgt, PAIR_STEP) == 24'h0);
  end

  flash_row_unpack u_unpack (
    .i_compressed(format),
    .i_w0(wbuf[0]),
    .i_w1(wbuf[1]),
    .i_w2(wbuf[2]),
    .i_w3(wbuf[3]),
    .o_instr0(up0),
    .o_instr1(up1)
  );

  // ==========================================================
  // Unlock key sequence; a control write, any other key write or timeout relocks
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      key_stage <= 2'h0;
      key_age <= 8'h00;
    end else if (I_WR && I_ADDR == OFS_KEY && I_WDATA[15:0] == KEY_A) begin
      key_stage <= 2'h1;
      key_age <= 8'h00;
    end else if (I_WR && I_ADDR == OFS_KEY && I_WDATA[15:0] == KEY_B && key_stage == 2'h1) begin
      key_stage <= 2'h2;
      key_age <= 8'h00;
    end else if (wr_ctl || (I_WR && I_ADDR == OFS_KEY)) begin
      key_stage <= 2'h0;
    end else if (key_stage != 2'h0) begin
      if (key_age >= 8'(KEY_WINDOW - 1))
        key_stage <= 2'h0;
      else
        key_age <= key_age + 8'h01;
    end
  end

  // ==========================================================
  // Control, pointers and latches
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      start <= 1'b0;
      format <= 1'b0;
      op <= 2'h0;
    end else if (go && unlocked && aligned) begin
      start <= 1'b1;
      format <= I_WDATA[CTL_FORMAT_BIT];
      op <= I_WDATA[CTL_OP_LSB +: 2];
    end else if (wr_ctl && state == S_IDLE) begin
      format <= I_WDATA[CTL_FORMAT_BIT];
      op <= I_WDATA[CTL_OP_LSB +: 2];
    end else if (state == S_DONE) begin
      start <= 1'b0;
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      src <= 16'h0000;
      tgt <= 24'h000000;
      latch0 <= 24'h000000;
      latch1 <= 24'h000000;
    end else if (state == S_IDLE) begin
      if (I_WR && I_ADDR == OFS_SRC)
        src <= I_WDATA[15:0];
      if (I_WR && I_ADDR == OFS_TGT)
        tgt <= I_WDATA;
      if (I_WR && I_ADDR == OFS_LATCH_LO)
        latch0 <= I_WDATA;
      if (I_WR && I_ADDR == OFS_LATCH_HI)
        latch1 <= I_WDATA;
    end else if (state == S_FETCH) begin
      src <= src + 16'h0002;
    end else if (state == S_PROG && wait_cnt == 16'h0001) begin
      tgt <= tgt + 24'(PAIR_STEP);
    end
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      state <= S_IDLE;
      wait_cnt <= 16'h0000;
      word_idx <= 3'h0;
      pair_cnt <= 7'h00;
      for (int i = 0; i < 4; i++)
        wbuf[i] <= 16'h0000;
    end else begin
      case (state)
        S_IDLE: begin
          word_idx <= 3'h0;
          pair_cnt <= 7'h00;
          if (go && unlocked && aligned) begin
            if (I_WDATA[CTL_OP_LSB +: 2] == OP_ERASE) begin
              state <= S_ERASE;
              wait_cnt <= 16'(ERASE_WAIT);
            end else if (I_WDATA[CTL_OP_LSB +: 2] == OP_ROW) begin
              state <= S_FETCH;
            end else begin
              state <= S_PROG;
              wait_cnt <= 16'(WORD_WAIT);
            end
          end
        end
        S_ERASE: begin
          wait_cnt <= wait_cnt - 16'h0001;
          if (wait_cnt == 16'h0001)
            state <= S_DONE;
        end
        S_FETCH: begin
          state <= S_WAITD;
        end
        S_WAITD: begin
          // RAM answers in the same cycle as the read strobe, which rises one cycle after S_FETCH
          wbuf[word_idx[1:0]] <= I_RAM_DATA;
          if (word_idx == words_per_pair - 3'h1) begin
            word_idx <= 3'h0;
            state <= S_PROG;
            wait_cnt <= 16'(WORD_WAIT);
          end else begin
            word_idx <= word_idx + 3'h1;
            state <= S_FETCH;
          end
        end
        S_PROG: begin
          wait_cnt <= wait_cnt - 16'h0001;
          if (wait_cnt == 16'h0001) begin
            if (op == OP_ROW && pair_cnt != 7'(ROW_INSTR / 2 - 1)) begin
              pair_cnt <= pair_cnt + 7'h01;
              state <= S_FETCH;
            end else begin
              state <= S_DONE;
            end
          end
        end
        S_DONE: begin
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Flash and RAM strobes, stall
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_RAM_RD <= 1'b0;
      O_RAM_ADDR <= 16'h0000;
      O_FLASH_ERASE <= 1'b0;
      O_FLASH_WRITE <= 1'b0;
      O_FLASH_ADDR <= 24'h000000;
      O_FLASH_DATA <= 24'h000000;
      O_CPU_STALL <= 1'b0;
    end else begin
      O_RAM_RD <= (state == S_FETCH);
      O_RAM_ADDR <= src;
      O_FLASH_ERASE <= (state == S_ERASE) && (wait_cnt == 16'(ERASE_WAIT));
      O_FLASH_WRITE <= (state == S_PROG) && (wait_cnt == 16'(WORD_WAIT));
      O_FLASH_ADDR <= tgt;
      // Second instruction of the pair follows in the cycle after the write pulse
      O_FLASH_DATA <= O_FLASH_WRITE ? ((op == OP_ROW) ? up1 : latch1) : ((op == OP_ROW) ? up0 : latch0);
      O_CPU_STALL <= (go && unlocked && aligned) || (state != S_IDLE && state != S_DONE);
    end
  end

  // ==========================================================
  // Interrupts: set beats clear
  always_comb begin
    irq_set = 3'h0;
    irq_set[ST_DONE] = (state == S_DONE);
    irq_set[ST_REFUSED] = go && !unlocked;
    irq_set[ST_ALIGN] = go && unlocked && !aligned;
  end

  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      irq_status <= IRQ_RESET;
      irq_enable <= IRQ_RESET;
      O_IRQ <= 1'b0;
    end else begin
      if (I_WR && I_ADDR == OFS_IRQ_CLR)
        irq_status <= (irq_status & ~I_WDATA[2:0]) | irq_set;
      else
        irq_status <= irq_status | irq_set;
      if (I_WR && I_ADDR == OFS_IRQ_EN)
        irq_enable <= I_WDATA[2:0];
      O_IRQ <= |((irq_status | irq_set) & irq_enable);
    end
  end

  // ==========================================================
  // Register read
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_RDATA <= 24'h000000;
    end else if (I_RD) begin
      if (I_ADDR == OFS_CONTROL)
        O_RDATA <= {8'h00, start, 5'h00, format, 7'h00, op};
      else if (I_ADDR == OFS_SRC)
        O_RDATA <= {8'h00, src};
      else if (I_ADDR == OFS_TGT)
        O_RDATA <= tgt;
      else if (I_ADDR == OFS_STATUS)
        O_RDATA <= {21'h000000, irq_status};
      else if (I_ADDR == OFS_IRQ_EN)
        O_RDATA <= {21'h000000, irq_enable};
      else if (I_ADDR == OFS_LATCH_LO)
        O_RDATA <= latch0;
      else if (I_ADDR == OFS_LATCH_HI)
        O_RDATA <= latch1;
      else
        O_RDATA <= 24'h000000;
    end else begin
      O_RDATA <= 24'h000000;
    end
  end

  // Cycles spent in erase; a counter, since the wait may run to 65535 cycles
  logic [15:0] erase_age;
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST)
      erase_age <= 16'h0000;
    else
      erase_age <= (state == S_ERASE) ? erase_age + 16'h0001 : 16'h0000;
  end

  // ==========================================================
  // Checks
  chk_start_locked: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (go && !unlocked) |=> (state == S_IDLE && !start)) else $error("start accepted while locked");
  chk_relock_after: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    wr_ctl |=> !unlocked) else $error("key not relocked");
  chk_stall_busy: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (state == S_ERASE || state == S_PROG) |=> O_CPU_STALL) else $error("cpu not stalled");
  chk_start_clear: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (state == S_DONE) |=> !start ##1 (state == S_IDLE || $past(go))) else $error("start not cleared");
  chk_done_irq: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (state == S_DONE && irq_enable[ST_DONE]) |=> O_IRQ) else $error("done irq missing");
  chk_erase_len: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (state == S_ERASE) |=> (state == (($past(erase_age) < 16'(ERASE_WAIT - 1)) ? S_ERASE : S_DONE)))
    else $error("erase length wrong");
  chk_pair_align: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (O_FLASH_WRITE && op == OP_PAIR) |-> (O_FLASH_ADDR[1:0] == 2'h0)) else $error("pair misaligned");
  chk_ram_advance: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (state == S_FETCH) |=> (src == $past(src) + 16'h0002)) else $error("source not advanced");
  chk_row_count: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (state == S_PROG && op == OP_ROW) |-> (pair_cnt < 7'(ROW_INSTR / 2))) else $error("row overrun");
  chk_fmt_held: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    (state != S_IDLE) |=> $stable(format)) else $error("format changed mid operation");
  cov_erase: cover property (@(posedge I_CLOCK) disable iff (I_SYS_RST) O_FLASH_ERASE);
  cov_row_done: cover property (@(posedge I_CLOCK) disable iff (I_SYS_RST) state == S_DONE && op == OP_ROW);
  cov_refused: cover property (@(posedge I_CLOCK) disable iff (I_SYS_RST) irq_set[ST_REFUSED]);
endmodule : flash_self_program_sequencer
`default_nettype wire

// >>> flash_self_program_sequencer_tb.sv
// Self-checking testbench for the flash self-programming sequencer
`timescale 1ns/1ns
`default_nettype none
module flash_self_program_sequencer_tb;
  import flash_seq_pkg::*;
  // Short waits keep each erase and word-program wait to four cycles
  localparam int WAIT_SMALL = 4;
  logic clock, sys_rst, wr, rd, irq, stall, ram_rd, fl_erase, fl_write, clear;
  logic [3:0] addr;
  logic [23:0] wdata, rdata, fl_addr, fl_data, rv;
  logic [15:0] ram_addr, ram_data, reads, last_raddr, writes, erases;
  logic [23:0] erase_addr, first_addr, first_data, last_addr, last_data, first_data2, last_data2;
  int miscompares, compares, cycles;
  // ==========================================================
  // Design and far side
  flash_self_program_sequencer #(.ERASE_WAIT(WAIT_SMALL), .WORD_WAIT(WAIT_SMALL)) flash_self_program_sequencer_i (
    .I_CLOCK(clock), .I_SYS_RST(sys_rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .O_IRQ(irq), .O_CPU_STALL(stall), .O_RAM_RD(ram_rd), .O_RAM_ADDR(ram_addr),
    .I_RAM_DATA(ram_data), .O_FLASH_ERASE(fl_erase), .O_FLASH_WRITE(fl_write), .O_FLASH_ADDR(fl_addr),
    .O_FLASH_DATA(fl_data));
  flash_far_model flash_far_model_i (
    .i_clk(clock), .i_rst(sys_rst), .i_clear(clear), .i_ram_rd(ram_rd), .i_ram_addr(ram_addr),
    .o_ram_data(ram_data), .i_erase(fl_erase), .i_write(fl_write), .i_addr(fl_addr), .i_data(fl_data),
    .o_reads(reads), .o_last_raddr(last_raddr), .o_writes(writes), .o_erases(erases),
    .o_erase_addr(erase_addr), .o_first_addr(first_addr), .o_first_data(first_data),
    .o_last_addr(last_addr), .o_last_data(last_data), .o_first_data2(first_data2), .o_last_data2(last_data2));
  // ==========================================================
  // Clock and hang guard
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  // ==========================================================
  // Tasks
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic reg_wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    rv = rdata;
  endtask : reg_rd
  // First instruction of the pair whose image starts at RAM byte a
  function automatic logic [23:0] first_instr(input logic [15:0] a);
    logic [15:0] lo;
    logic [15:0] hi;
    lo = {a[7:0] ^ 8'h3C, a[8:1]};
    hi = {(a[7:0] + 8'h02) ^ 8'h3C, (a[8:1] + 8'h01)};
    return {hi[7:0], lo};
  endfunction : first_instr
  // RAM word held at byte a by the far-side model
  function automatic logic [15:0] ram_word(input logic [15:0] a);
    return {a[7:0] ^ 8'h3C, a[8:1]};
  endfunction : ram_word
  // Second instruction of the pair whose image starts at RAM byte a
  function automatic logic [23:0] second_instr(input logic [15:0] a, input logic packed_img);
    logic [15:0] w1;
    logic [15:0] w2;
    logic [15:0] w3;
    w1 = ram_word(a + 16'h0002);
    w2 = ram_word(a + 16'h0004);
    w3 = ram_word(a + 16'h0006);
    return packed_img ? {w1[15:8], w2} : {w3[7:0], w2};
  endfunction : second_instr
  // Keys, start, then wait out the stall under a bound
  task automatic run_op(input logic [23:0] ctl, input logic [15:0] ka, input logic [15:0] kb,
                        input logic busy, input logic [23:0] status);
    int n;
    n = 0;
    @(posedge clock);
    clear <= 1'b1;
    @(posedge clock);
    clear <= 1'b0;
    reg_wr(OFS_IRQ_CLR, 24'h000007);
    reg_wr(OFS_KEY, {8'h00, ka});
    reg_wr(OFS_KEY, {8'h00, kb});
    reg_wr(OFS_CONTROL, ctl);
    @(posedge clock);
    #1;
    check({23'h0, stall}, {23'h0, busy});
    while (stall !== 1'b0 && n < 2000) begin
      @(posedge clock);
      #1;
      n++;
    end
    check({23'h0, stall}, 24'h0);
    reg_rd(OFS_CONTROL);
    check({23'h0, rv[CTL_START_BIT]}, 24'h0);
    reg_rd(OFS_STATUS);
    check(rv, status);
  endtask : run_op
  // ==========================================================
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    addr = 4'h0;
    wdata = 24'h000000;
    wr = 1'b0;
    rd = 1'b0;
    clear = 1'b0;
    miscompares = 0;
    compares = 0;
    cycles = 0;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    #1;
    check({22'h0, irq, stall}, 24'h0);
    reg_rd(OFS_STATUS);
    check(rv, 24'h000000);
    reg_rd(4'hF);
    check(rv, 24'h000000);
    // Start without keys, then with keys in the wrong order
    run_op(24'h008001, 16'h0000, 16'h0000, 1'b0, 24'h000002);
    run_op(24'h008001, KEY_SECOND, KEY_FIRST, 1'b0, 24'h000002);
    check({8'h00, writes}, 24'h0);
    // Pair from the latches at an aligned target
    reg_wr(OFS_LATCH_LO, 24'h123456);
    reg_wr(OFS_LATCH_HI, 24'h00ABCD);
    reg_wr(OFS_TGT, 24'h000004);
    run_op(24'h008001, KEY_FIRST, KEY_SECOND, 1'b1, 24'h000001);
    check({8'h00, writes}, 24'h000001);
    check(first_addr, 24'h000004);
    check(first_data, 24'h123456);
    check(first_data2, 24'h00ABCD);
    // Interrupt masked, enabled, cleared
    check({23'h0, irq}, 24'h0);
    reg_wr(OFS_IRQ_EN, 24'h000001);
    repeat (2) @(posedge clock);
    #1;
    check({23'h0, irq}, 24'h000001);
    reg_wr(OFS_IRQ_CLR, 24'h000001);
    repeat (2) @(posedge clock);
    #1;
    check({23'h0, irq}, 24'h0);
    reg_wr(OFS_IRQ_EN, 24'h000000);
    // Start with no fresh keys after a spent unlock
    reg_wr(OFS_CONTROL, 24'h008001);
    reg_rd(OFS_STATUS);
    check(rv, 24'h000002);
    // Keys spent by the last attempt, then a misaligned pair
    run_op(24'h008001, 16'h0000, 16'h0000, 1'b0, 24'h000002);
    reg_wr(OFS_TGT, 24'h000006);
    run_op(24'h008001, KEY_FIRST, KEY_SECOND, 1'b0, 24'h000004);
    // Page erase, aligned then misaligned
    reg_wr(OFS_TGT, 24'h000400);
    run_op(24'h008003, KEY_FIRST, KEY_SECOND, 1'b1, 24'h000001);
    check({8'h00, erases}, 24'h000001);
    check(erase_addr, 24'h000400);
    reg_wr(OFS_TGT, 24'h000600);
    run_op(24'h008003, KEY_FIRST, KEY_SECOND, 1'b0, 24'h000004);
    check({8'h00, erases}, 24'h0);
    // Rows: uncompressed, compressed, misaligned
    reg_wr(OFS_SRC, 24'h000100);
    reg_wr(OFS_TGT, 24'h000080);
    run_op(24'h008002, KEY_FIRST, KEY_SECOND, 1'b1, 24'h000001);
    check({8'h00, writes}, 24'h000020);
    check({8'h00, reads}, 24'h000080);
    check({8'h00, last_raddr}, 24'h0001FE);
    check(first_addr, 24'h000080);
    check(last_addr, 24'h0000FC);
    check(first_data, first_instr(16'h0100));
    check(last_data, first_instr(16'h01F8));
    check(first_data2, second_instr(16'h0100, 1'b0));
    check(last_data2, second_instr(16'h01F8, 1'b0));
    reg_wr(OFS_SRC, 24'h000100);
    reg_wr(OFS_TGT, 24'h000080);
    run_op(24'h008202, KEY_FIRST, KEY_SECOND, 1'b1, 24'h000001);
    check({8'h00, writes}, 24'h000020);
    check({8'h00, reads}, 24'h000060);
    check({8'h00, last_raddr}, 24'h0001BE);
    check(first_data, first_instr(16'h0100));
    check(last_data, first_instr(16'h01BA));
    check(first_data2, second_instr(16'h0100, 1'b1));
    check(last_data2, second_instr(16'h01BA, 1'b1));
    reg_wr(OFS_TGT, 24'h000040);
    run_op(24'h008002, KEY_FIRST, KEY_SECOND, 1'b0, 24'h000004);
    close_out();
  end
endmodule : flash_self_program_sequencer_tb
`default_nettype wire

// >>> flash_seq_pkg.sv
// Constants shared by the flash self-programming sequencer
package flash_seq_pkg;
  // ==========================================================
  // Geometry
  localparam int ROW_INSTR = 64;
  localparam int ROW_BYTES = 192;
  localparam int PAGE_ROWS = 8;
  localparam int PAGE_INSTR = 512;
  localparam int PAGE_BYTES = 1536;
  localparam int PAIR_STEP = 4;
  // ==========================================================
  // Register offsets (word index on the plain port)
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_KEY = 4'h1;
  localparam logic [3:0] OFS_SRC = 4'h2;
  localparam logic [3:0] OFS_TGT = 4'h3;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_IRQ_EN = 4'h5;
  localparam logic [3:0] OFS_IRQ_CLR = 4'h6;
  localparam logic [3:0] OFS_LATCH_LO = 4'h7;
  localparam logic [3:0] OFS_LATCH_HI = 4'h8;
  // ==========================================================
  // Control fields
  localparam int CTL_START_BIT = 15;
  localparam int CTL_FORMAT_BIT = 9;
  localparam int CTL_OP_LSB = 0;
  localparam logic [1:0] OP_PAIR = 2'h1;
  localparam logic [1:0] OP_ROW = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  // Status / interrupt bits
  localparam int ST_DONE = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_ALIGN = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  // ==========================================================
  // Unlock keys (arbitrary values) and timing
  localparam logic [15:0] KEY_FIRST = 16'h0055;
  localparam logic [15:0] KEY_SECOND = 16'h00AA;
  localparam int KEY_WINDOW_CYCLES = 8;
  localparam int CLK_MHZ = 25;
  localparam int ERASE_TIME_US = 40;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
  localparam int WORD_TIME_US = 4;
  localparam int WORD_CYCLES = WORD_TIME_US * CLK_MHZ;
endpackage : flash_seq_pkg
